/* cgb_gain_bank.sv */
`timescale 1ns/1ps
`include "cgb_defs.svh"
// Behaviour
// - Channel 0 code in bits 2:0
// - Channel 1 code in bits 6:4
// - Channel 2 code in bits 10:8
// - Channel 3 code in bits 14:12
// - Reset clears register, all gains one
module cgb_gain_bank
	import cgb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic [2:0] ch0_gain_code,
	output logic [2:0] ch1_gain_code,
	output logic [2:0] ch2_gain_code,
	output logic [2:0] ch3_gain_code,
	output logic [7:0] ch0_gain_factor,
	output logic [7:0] ch1_gain_factor,
	output logic [7:0] ch2_gain_factor,
	output logic [7:0] ch3_gain_factor,
	output logic gain_updated
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Each code step doubles the gain, starting at one; a table keeps
	// the mapping easy to hold against the code list
	function automatic cgb_factor_t gain_factor(input cgb_code_t code);
		case (code)
			3'h0: gain_factor = 8'h01;
			3'h1: gain_factor = 8'h02;
			3'h2: gain_factor = 8'h04;
			3'h3: gain_factor = 8'h08;
			3'h4: gain_factor = 8'h10;
			3'h5: gain_factor = 8'h20;
			3'h6: gain_factor = 8'h40;
			3'h7: gain_factor = 8'h80;
			default: gain_factor = 8'h01;
		endcase
	endfunction

	function automatic cgb_code_t field(input logic [15:0] word,
		input int lsb);
		field = word[lsb +: 3];
	endfunction

	// Any reserved bit set in a word bound for the gain register
	function automatic logic rsvd_set(input logic [15:0] word);
		rsvd_set = |(word & `CGB_RSVD_MASK);
	endfunction

	// Status layout: sticky flag in bit 0, write count in bits 15:8
	function automatic logic [31:0] status_word(input logic seen,
		input logic [7:0] count);
		status_word = 32'h0;
		status_word[`CGB_ST_RSVD_BIT] = seen;
		status_word[`CGB_ST_CNT_LSB +: 8] = count;
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	typedef enum {
		CGB_SEL_NONE,
		CGB_SEL_GAIN,
		CGB_SEL_STATUS
	} cgb_sel_e;

	// Only the low twelve address bits take part in the decode
	function automatic cgb_sel_e sel_of(input logic [11:0] addr);
		case (addr)
			`CGB_GAIN_LOW_ADDR: sel_of = CGB_SEL_GAIN;
			`CGB_STATUS_ADDR: sel_of = CGB_SEL_STATUS;
			default: sel_of = CGB_SEL_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] gain_low;
		cgb_factor_t fac0;
		cgb_factor_t fac1;
		cgb_factor_t fac2;
		cgb_factor_t fac3;
		logic rsvd_seen;
		logic [7:0] wr_count;
		logic updated;
	} cgb_bank_s;

	cgb_bank_s st_r;
	cgb_bank_s st_nxt;

	cgb_if bus ();

	cgb_apb_slave u_apb (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.bus(bus)
	);

	// ----------------------------------------
	// Read and write decode
	// ----------------------------------------
	cgb_sel_e sel;
	logic hit_gain;
	logic hit_status;
	logic wr_gain;
	logic wr_status;
	logic [15:0] wr_word;

	assign sel = sel_of(bus.addr);
	assign hit_gain = (sel == CGB_SEL_GAIN);
	assign hit_status = (sel == CGB_SEL_STATUS);
	// Only a committed access phase may touch storage
	assign wr_gain = bus.wr_stb && hit_gain;
	assign wr_status = bus.wr_stb && hit_status;
	assign wr_word = bus.wdata[15:0];
	assign bus.hit = hit_gain || hit_status;

	// Unmapped reads return zero; the bridge flags them separately
	always_comb begin
		bus.rdata = 32'h0;
		case (sel)
			CGB_SEL_GAIN: begin
				bus.rdata[15:0] = st_r.gain_low;
			end
			CGB_SEL_STATUS: begin
				bus.rdata = status_word(st_r.rsvd_seen, st_r.wr_count);
			end
			default: begin
				bus.rdata = 32'h0;
			end
		endcase
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.updated = 1'b0;
		if (wr_gain) begin
			// Reserved bits are stored as written and read back
			st_nxt.gain_low = wr_word;
			st_nxt.updated = 1'b1;
			// Count wraps; it only shows that writes are landing
			st_nxt.wr_count = st_r.wr_count + 8'h01;
		end
		// Write one to clear; a new violation in the same cycle wins
		if (wr_status && bus.wdata[`CGB_ST_RSVD_BIT]) begin
			st_nxt.rsvd_seen = 1'b0;
		end
		if (wr_gain && rsvd_set(wr_word)) begin
			st_nxt.rsvd_seen = 1'b1;
		end
		st_nxt.fac0 = gain_factor(field(st_nxt.gain_low, `CGB_CH0_LSB));
		st_nxt.fac1 = gain_factor(field(st_nxt.gain_low, `CGB_CH1_LSB));
		st_nxt.fac2 = gain_factor(field(st_nxt.gain_low, `CGB_CH2_LSB));
		st_nxt.fac3 = gain_factor(field(st_nxt.gain_low, `CGB_CH3_LSB));
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{
				gain_low: `CGB_GAIN_LOW_RST,
				fac0: `CGB_FACTOR_RST,
				fac1: `CGB_FACTOR_RST,
				fac2: `CGB_FACTOR_RST,
				fac3: `CGB_FACTOR_RST,
				rsvd_seen: 1'b0,
				wr_count: 8'h00,
				updated: 1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Amplifier outputs
	// ----------------------------------------
	// codes presented continuously
	// Codes and factors share one edge, so they never disagree

	assign ch0_gain_code = st_r.gain_low[`CGB_CH0_LSB +: 3];
	assign ch0_gain_factor = st_r.fac0;

	assign ch1_gain_code = st_r.gain_low[`CGB_CH1_LSB +: 3];
	assign ch1_gain_factor = st_r.fac1;

	assign ch2_gain_code = st_r.gain_low[`CGB_CH2_LSB +: 3];
	assign ch2_gain_factor = st_r.fac2;

	assign ch3_gain_code = st_r.gain_low[`CGB_CH3_LSB +: 3];
	assign ch3_gain_factor = st_r.fac3;

	// Pulse for the cycle after a gain write lands
	assign gain_updated = st_r.updated;
endmodule

/* cgb_defs.svh */
`ifndef CGB_DEFS_SVH
`define CGB_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
// Register index; byte address is four times the index
`define CGB_GAIN_LOW_IDX 4'h4
`define CGB_GAIN_LOW_ADDR 12'h010
`define CGB_STATUS_ADDR 12'h040
`define CGB_ADDR_W 12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGB_CH0_LSB 0
`define CGB_CH1_LSB 4
`define CGB_CH2_LSB 8
`define CGB_CH3_LSB 12
`define CGB_RSVD_MASK 16'h8888
`define CGB_ST_RSVD_BIT 0
`define CGB_ST_CNT_LSB 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CGB_GAIN_LOW_RST 16'h0000
`define CGB_FACTOR_RST 8'h01

`endif

/* cgb_pkg.sv */
package cgb_pkg;
	typedef logic [2:0] cgb_code_t;
	typedef logic [7:0] cgb_factor_t;
	typedef enum logic [1:0] {
		CGB_IDLE,
		CGB_ACCESS
	} cgb_phase_e;
endpackage

/* cgb_if.sv */
`timescale 1ns/1ps
interface cgb_if;
	logic wr_stb;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic hit;
	modport slave (output wr_stb, output addr, output wdata,
		input rdata, input hit);
	modport regs (input wr_stb, input addr, input wdata,
		output rdata, output hit);
endinterface

/* cgb_apb_slave.sv */
`timescale 1ns/1ps
`include "cgb_defs.svh"
module cgb_apb_slave
	import cgb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	cgb_if.slave bus
);
	typedef struct packed {
		cgb_phase_e phase;
		logic ready;
		logic err;
		logic [31:0] rdata;
	} cgb_apb_s;

	cgb_apb_s st_r;
	cgb_apb_s st_nxt;

	// ----------------------------------------
	// Decode during setup, answer in access
	// ----------------------------------------
	// One wait-free access cycle: pready rises at the first access edge
	always_comb begin
		st_nxt = st_r;
		st_nxt.ready = 1'b0;
		case (st_r.phase)
			CGB_IDLE: begin
				if (psel && !penable) begin
					st_nxt.phase = CGB_ACCESS;
					st_nxt.ready = 1'b1;
					st_nxt.err = !bus.hit;
					st_nxt.rdata = (pwrite || !bus.hit) ? 32'h0 : bus.rdata;
				end
			end
			CGB_ACCESS: begin
				st_nxt.phase = CGB_IDLE;
				st_nxt.err = 1'b0;
				st_nxt.rdata = 32'h0;
				if (psel && !penable) begin
					st_nxt.phase = CGB_ACCESS;
					st_nxt.ready = 1'b1;
					st_nxt.err = !bus.hit;
					st_nxt.rdata = (pwrite || !bus.hit) ? 32'h0 : bus.rdata;
				end
			end
			default: begin
				st_nxt.phase = CGB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{phase: CGB_IDLE, ready: 1'b0, err: 1'b0,
				rdata: 32'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.addr = paddr[11:0];
	assign bus.wdata = pwdata;
	// Writes to unmapped addresses are dropped, not stored
	assign bus.wr_stb = psel && penable && st_r.ready && pwrite && !st_r.err;
	assign pready = st_r.ready;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.err;
endmodule

/* cgb_gain_bank_props.sv */
`timescale 1ns/1ps
module cgb_gain_bank_props (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic [2:0] ch0_gain_code,
	input wire logic [2:0] ch1_gain_code,
	input wire logic [2:0] ch2_gain_code,
	input wire logic [2:0] ch3_gain_code,
	input wire logic [7:0] ch0_gain_factor,
	input wire logic gain_updated
);
	// ----
	// Gain register access
	// ----
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_gwr;
		psel && penable && pready && pwrite && paddr[11:0] == 12'h010;
	endsequence
	sequence s_grd;
		psel && penable && pready && !pwrite && paddr[11:0] == 12'h010;
	endsequence
	property p_ch0;
		logic [31:0] d;
		(s_gwr, d = pwdata) |=> ch0_gain_code == d[2:0]
			&& ch0_gain_factor == 8'h01 << d[2:0];
	endproperty
	a_ch0: assert property (p_ch0) else $error("ch0 code");
	property p_ch1;
		logic [31:0] d;
		(s_gwr, d = pwdata) |=> ch1_gain_code == d[6:4];
	endproperty
	a_ch1: assert property (p_ch1) else $error("ch1 code");
	property p_ch2;
		logic [31:0] d;
		(s_gwr, d = pwdata) |=> ch2_gain_code == d[10:8];
	endproperty
	a_ch2: assert property (p_ch2) else $error("ch2 code");
	property p_ch3;
		logic [31:0] d;
		(s_gwr, d = pwdata) |=> ch3_gain_code == d[14:12];
	endproperty
	a_ch3: assert property (p_ch3) else $error("ch3 code");
	property p_rst;
		$rose(reset_n) |-> {ch3_gain_code, ch2_gain_code, ch1_gain_code,
			ch0_gain_code} == 12'h000 && ch0_gain_factor == 8'h01;
	endproperty
	a_rst: assert property (p_rst) else $error("reset gain");
	// Reads never disturb the codes the amplifiers see
	property p_hold;
		!pwrite |=> $stable({ch3_gain_code, ch2_gain_code, ch1_gain_code,
			ch0_gain_code});
	endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_rd;
		s_grd |-> prdata[14:12] == ch3_gain_code && prdata[10:8] ==
			ch2_gain_code && prdata[6:4] == ch1_gain_code
			&& prdata[2:0] == ch0_gain_code;
	endproperty
	a_rd: assert property (p_rd) else $error("readback");
	property p_upd;
		s_gwr |=> gain_updated;
	endproperty
	a_upd: assert property (p_upd) else $error("no update");
endmodule

/* test_cgb_gain_bank.sv */
`timescale 1ns/1ps
module test_cgb_gain_bank;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd, v;
	logic pready, pslverr, gain_updated, er;
	logic [2:0] c0, c1, c2, c3;
	logic [7:0] f0, f1, f2, f3;
	int n_mismatch = 0, samples_checked = 0;
	cgb_gain_bank u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ch0_gain_code(c0), .ch1_gain_code(c1),
		.ch2_gain_code(c2), .ch3_gain_code(c3), .ch0_gain_factor(f0),
		.ch1_gain_factor(f1), .ch2_gain_factor(f2), .ch3_gain_factor(f3),
		.gain_updated(gain_updated));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----
	// APB transfer, idle edge first so releases never collide
	// ----
	task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (i >= 20) begin
			n_mismatch++;
			end_of_test;
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1;
		apb(0, 32'h10, 0);
		chk("rst", rd, 0);
		for (int i = 0; i < 8; i++) begin
			v = i | (i ^ 1) << 4 | (i ^ 2) << 8 | (i ^ 4) << 12;
			apb(1, 32'h10, v);
			@(negedge sys_clk);
			chk("upd", gain_updated, 1);
			chk("f1", f1, 1 << (i ^ 1));
			chk("f2", f2, 1 << (i ^ 2));
			chk("f3", f3, 1 << (i ^ 4));
			chk("ch0", c0, i);
			chk("f0", f0, 1 << i);
			chk("ch1", c1, i ^ 1);
			chk("ch2", c2, i ^ 2);
			chk("ch3", c3, i ^ 4);
			apb(0, 32'h10, 0);
			chk("rd", rd, v);
		end
		apb(1, 32'h10, 32'h0000FFFF);
		apb(1, 32'h20, 0);
		chk("err", er, 1);
		apb(0, 32'h10, 0);
		chk("rsvd", rd, 32'h0000FFFF);
		apb(0, 32'h40, 0);
		chk("st", rd, 32'h00000901);
		apb(1, 32'h40, 1);
		apb(0, 32'h40, 0);
		chk("stclr", rd, 32'h00000900);
		reset_n <= 0;
		@(negedge sys_clk);
		chk("clr", {c3, c2, c1, c0}, 0);
		@(posedge sys_clk);
		reset_n <= 1;
		apb(0, 32'h10, 0);
		chk("rst2", rd, 0);
		end_of_test;
	end
endmodule
bind cgb_gain_bank cgb_gain_bank_props u_props (.sys_clk(sys_clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.ch0_gain_code(ch0_gain_code), .ch1_gain_code(ch1_gain_code),
	.ch2_gain_code(ch2_gain_code), .ch3_gain_code(ch3_gain_code),
	.ch0_gain_factor(ch0_gain_factor), .gain_updated(gain_updated));
